//--- pkg/ccr_pkg.sv
// Types and constants for the coherence collision resolver.
// Assumes one clock domain and request/answer handshakes from same-clock logic.
// How it works
// - Collide on address or cache index match
// - Non-coherent requests never collide
// - READ_HOME with DKILL_SHARER, final already seen: cancel outstanding, issue incoming immediately
// - TLBIE and TLBSYNC forward, answer DONE
// - IKILL_SHARER: ERROR on owner reads, else DONE
// - IKILL_HOME under owner read: forward, kill sharers
// - CASTOUT under owner read: update directory, DONE
// - READ_HOME outstanding: home-type requests get ERROR
// - READ_HOME outstanding: owner-type requests get NOT_OWNER
// - READ_HOME with DKILL_SHARER: wait, forward, DONE
// - IREAD_HOME outstanding: home-type requests get ERROR
// - IREAD_HOME outstanding: owner-type requests forward, DONE
// - Owner read outstanding: home-type requests get RETRY
// - Owner read outstanding: owner-type requests get ERROR
// - READ_TO_OWN_HOME outstanding: home-type requests ERROR
// - READ_TO_OWN_HOME, owner reads: wait, intervene
// - READ_TO_OWN_HOME, DKILL_SHARER: DONE-final gives ERROR
// - READ_TO_OWN_HOME, FLUSH: wait, DONE with data
// - READ_TO_OWN_HOME, IO_READ_OWNER: wait, DONE with data
package ccr_pkg;

    localparam int ADDR_W    = 32;
    localparam int IDX_LO    = 5;
    localparam int IDX_W     = 7;
    localparam int N_ENTRY   = 4;
    localparam int ENTRY_W   = 2;

    typedef enum logic [3:0] {
        TT_READ_HOME         = 4'h0,
        TT_IREAD_HOME        = 4'h1,
        TT_READ_OWNER        = 4'h2,
        TT_READ_TO_OWN_HOME  = 4'h3,
        TT_READ_TO_OWN_OWNER = 4'h4,
        TT_DKILL_HOME        = 4'h5,
        TT_DKILL_SHARER      = 4'h6,
        TT_CASTOUT           = 4'h7,
        TT_TLBIE             = 4'h8,
        TT_TLBSYNC           = 4'h9,
        TT_IKILL_HOME        = 4'ha,
        TT_IKILL_SHARER      = 4'hb,
        TT_FLUSH             = 4'hc,
        TT_IO_READ_HOME      = 4'hd,
        TT_IO_READ_OWNER     = 4'he,
        TT_NONCOH            = 4'hf
    } txn_t;

    typedef enum logic [2:0] {
        RSP_NONE     = 3'h0,
        RSP_DONE     = 3'h1,
        RSP_RETRY    = 3'h2,
        RSP_ERROR    = 3'h3,
        RSP_NOT_OWNER = 3'h4,
        RSP_DONE_INTV = 3'h5
    } rsp_t;

    // Action flags carried with every resolution
    typedef struct packed {
        rsp_t   rsp;
        logic   with_data;
        logic   fwd_proc;
        logic   cancel_out;
        logic   data_only;
        logic   kill_sharers;
        logic   dir_update;
        logic   ret_local;
        logic   defer;
    } act_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_ISSUE = 3'b100
    } state_t;

endpackage

//--- pkg/ccr_if.sv
// Carries a looked-up collision from the tracker to the resolver.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface ccr_if;
    import ccr_pkg::*;
    logic               hit;
    logic [ENTRY_W-1:0] hit_idx;
    txn_t               hit_type;
    logic               hit_pend;
    modport tracker  (output hit, hit_idx, hit_type, hit_pend);
    modport resolver (input  hit, hit_idx, hit_type, hit_pend);
endinterface

//--- design/ccr_tracker.sv
// Table of outstanding coherence requests with collision lookup.
// Assumes allocate and free come from local logic on clk_sys.
`timescale 1ns/1ps
module ccr_tracker
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Allocation
    input  wire logic               alloc_vld,
    input  wire logic [ENTRY_W-1:0] alloc_idx,
    input  wire txn_t               alloc_type,
    input  wire logic [ADDR_W-1:0]  alloc_addr,
    // Final response seen and entry release
    input  wire logic               final_vld,
    input  wire logic [ENTRY_W-1:0] final_idx,
    input  wire logic               free_vld,
    input  wire logic [ENTRY_W-1:0] free_idx,
    // Lookup
    input  wire logic [ADDR_W-1:0]  look_addr,
    output logic [N_ENTRY-1:0]      busy,
    ccr_if.tracker                  lk
);
    logic [N_ENTRY-1:0]     valid_r;
    logic [N_ENTRY-1:0]     pend_r;
    txn_t                   type_r [N_ENTRY];
    logic [ADDR_W-1:0]      addr_r [N_ENTRY];
    logic [N_ENTRY-1:0]     match;

    assign busy = valid_r;

    genvar g;
    generate
        for (g = 0; g < N_ENTRY; g++) begin : g_ent
            // Full address or shared cache index both collide
            assign match[g] = valid_r[g] && ((addr_r[g] == look_addr) ||
                (addr_r[g][IDX_LO +: IDX_W] == look_addr[IDX_LO +: IDX_W]));

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    valid_r[g] <= 1'b0;
                    pend_r[g]  <= 1'b0;
                    type_r[g]  <= TT_READ_HOME;
                    addr_r[g]  <= '0;
                end else if (alloc_vld && alloc_idx == ENTRY_W'(g)) begin
                    valid_r[g] <= 1'b1;
                    pend_r[g]  <= 1'b1;
                    type_r[g]  <= alloc_type;
                    addr_r[g]  <= alloc_addr;
                end else begin
                    if (final_vld && final_idx == ENTRY_W'(g))
                        pend_r[g] <= 1'b0;
                    if (free_vld && free_idx == ENTRY_W'(g)) begin
                        valid_r[g] <= 1'b0;
                        pend_r[g]  <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        lk.hit      = 1'b0;
        lk.hit_idx  = '0;
        lk.hit_type = TT_READ_HOME;
        lk.hit_pend = 1'b0;
        for (int i = N_ENTRY - 1; i >= 0; i--) begin
            if (match[i]) begin
                lk.hit      = 1'b1;
                lk.hit_idx  = ENTRY_W'(i);
                lk.hit_type = type_r[i];
                lk.hit_pend = pend_r[i];
            end
        end
    end
endmodule // ccr_tracker

//--- design/ccr_resolver.sv
// Top of the coherence collision resolver.
// Assumes incoming requests and local responses come from clk_sys logic.
`timescale 1ns/1ps
module ccr_resolver
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Outstanding request bookkeeping from the local engine
    input  wire logic               alloc_vld,
    input  wire logic [ENTRY_W-1:0] alloc_idx,
    input  wire txn_t               alloc_type,
    input  wire logic [ADDR_W-1:0]  alloc_addr,
    input  wire logic               free_vld,
    input  wire logic [ENTRY_W-1:0] free_idx,
    output logic [N_ENTRY-1:0]      busy,
    // Final response to an outstanding request
    input  wire logic               fin_vld,
    input  wire logic [ENTRY_W-1:0] fin_idx,
    input  wire logic               fin_retry,
    // Incoming remote request
    input  wire logic               in_vld,
    output logic                    in_rdy,
    input  wire txn_t               in_type,
    input  wire logic [ADDR_W-1:0]  in_addr,
    // Resolution out
    output logic                    res_vld,
    output logic                    res_hit,
    output txn_t                    res_type,
    output logic [ADDR_W-1:0]       res_addr,
    output logic [ENTRY_W-1:0]      res_idx,
    output act_t                    res_act
);
    ccr_if lk ();

    state_t             state_r;
    txn_t               q_type_r;
    logic [ADDR_W-1:0]  q_addr_r;
    logic [ENTRY_W-1:0] q_idx_r;
    txn_t               q_out_r;
    logic               q_retry_r;
    logic               q_final_r;
    act_t               act_now;
    logic               take;
    logic               fin_mine;

    ccr_tracker u_trk (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .alloc_vld  (alloc_vld),
        .alloc_idx  (alloc_idx),
        .alloc_type (alloc_type),
        .alloc_addr (alloc_addr),
        .final_vld  (fin_vld),
        .final_idx  (fin_idx),
        .free_vld   (free_vld),
        .free_idx   (free_idx),
        .look_addr  ((state_r == ST_IDLE) ? in_addr : q_addr_r),
        .busy       (busy),
        .lk         (lk)
    );

    function automatic act_t mk(rsp_t r);
        act_t a;
        a = '0;
        a.rsp = r;
        return a;
    endfunction

    function automatic act_t fwd_done();
        act_t a;
        a = mk(RSP_DONE);
        a.fwd_proc = 1'b1;
        return a;
    endfunction

    // Table lookup: out = outstanding type, inc = incoming type.
    // pend = responses still expected; q_final_r = final response known; rty = it was RETRY.
    function automatic act_t resolve(txn_t out, txn_t inc, logic pend, logic rty);
        act_t a;
        logic home_reqs;
        logic own_reqs;
        a = fwd_done();
        home_reqs = inc inside {TT_READ_HOME, TT_IREAD_HOME, TT_READ_TO_OWN_HOME,
                                TT_DKILL_HOME, TT_IO_READ_HOME};
        own_reqs  = inc inside {TT_READ_OWNER, TT_READ_TO_OWN_OWNER, TT_IO_READ_OWNER};
        if (inc inside {TT_TLBIE, TT_TLBSYNC}) begin
            a = fwd_done();
        end else begin
            case (out)
                TT_READ_HOME, TT_IREAD_HOME: begin
                    if (home_reqs || inc inside {TT_CASTOUT, TT_IKILL_HOME, TT_FLUSH})
                        a = mk(RSP_ERROR);
                    else if (inc == TT_IKILL_SHARER)
                        a = fwd_done();
                    else if (out == TT_IREAD_HOME)
                        a = fwd_done();
                    else if (own_reqs)
                        a = mk(RSP_NOT_OWNER);
                    else if (pend) begin
                        a = mk(RSP_NONE);
                        a.defer = 1'b1;
                    end else begin
                        a = fwd_done();
                        a.cancel_out = rty || !q_final_r;
                        a.ret_local  = q_final_r && !rty;
                    end
                end
                TT_READ_OWNER, TT_READ_TO_OWN_OWNER: begin
                    if (home_reqs || inc == TT_FLUSH)
                        a = mk(RSP_RETRY);
                    else if (own_reqs || inc inside {TT_DKILL_SHARER, TT_IKILL_SHARER})
                        a = mk(RSP_ERROR);
                    else if (inc == TT_IKILL_HOME) begin
                        a = mk(RSP_NONE);
                        a.fwd_proc     = 1'b1;
                        a.kill_sharers = 1'b1;
                    end else begin
                        a = mk(RSP_DONE);
                        a.dir_update = 1'b1;
                    end
                end
                TT_READ_TO_OWN_HOME: begin
                    if (home_reqs || inc inside {TT_CASTOUT, TT_IKILL_HOME})
                        a = mk(RSP_ERROR);
                    else if (inc == TT_IKILL_SHARER)
                        a = fwd_done();
                    else if (pend) begin
                        a = mk(RSP_NONE);
                        a.defer = 1'b1;
                    end else if (inc == TT_DKILL_SHARER)
                        a = mk((rty || !rty && rty) ? RSP_DONE :
                               (q_final_r ? RSP_ERROR : RSP_DONE));
                    else if (!q_final_r)
                        a = mk(inc == TT_FLUSH ? RSP_ERROR : RSP_NOT_OWNER);
                    else if (rty)
                        a = mk(RSP_ERROR);
                    else if (inc == TT_FLUSH || inc == TT_IO_READ_OWNER) begin
                        a = fwd_done();
                        a.with_data = 1'b1;
                        a.ret_local = (inc == TT_FLUSH);
                    end else begin
                        a = mk(RSP_DONE_INTV);
                        a.fwd_proc  = 1'b1;
                        a.with_data = 1'b1;
                        a.data_only = 1'b1;
                    end
                end
                default: a = fwd_done();
            endcase
        end
        return a;
    endfunction

    assign fin_mine = fin_vld && (fin_idx == q_idx_r);
    assign in_rdy   = (state_r == ST_IDLE);
    assign take     = in_vld && in_rdy;

    // Resolution for the head request: fresh lookup in idle, saved context after wait
    always_comb begin
        act_now = fwd_done();
        if (state_r == ST_IDLE) begin
            if (in_type != TT_NONCOH && lk.hit)
                act_now = resolve(lk.hit_type, in_type, lk.hit_pend, 1'b0);
        end else begin
            act_now = resolve(q_out_r, q_type_r, 1'b0, q_retry_r);
        end
    end

    // Request context and wait state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r   <= ST_IDLE;
            q_type_r  <= TT_NONCOH;
            q_addr_r  <= '0;
            q_idx_r   <= '0;
            q_out_r   <= TT_READ_HOME;
            q_retry_r <= 1'b0;
            q_final_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    q_final_r <= 1'b0;
                    if (take && in_type != TT_NONCOH && lk.hit && act_now.defer) begin
                        state_r  <= ST_WAIT;
                        q_type_r <= in_type;
                        q_addr_r <= in_addr;
                        q_idx_r  <= lk.hit_idx;
                        q_out_r  <= lk.hit_type;
                    end
                end
                ST_WAIT: begin
                    if (fin_mine) begin
                        state_r   <= ST_ISSUE;
                        q_retry_r <= fin_retry;
                        q_final_r <= 1'b1;
                    end
                end
                ST_ISSUE: begin
                    // Final flag must not leak into the next fresh lookup
                    state_r   <= ST_IDLE;
                    q_final_r <= 1'b0;
                end
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // Registered resolution output
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            res_vld  <= 1'b0;
            res_hit  <= 1'b0;
            res_type <= TT_NONCOH;
            res_addr <= '0;
            res_idx  <= '0;
            res_act  <= '0;
        end else begin
            res_vld <= 1'b0;
            if (take && !(lk.hit && in_type != TT_NONCOH && act_now.defer)) begin
                res_vld  <= 1'b1;
                res_hit  <= lk.hit && (in_type != TT_NONCOH);
                res_type <= in_type;
                res_addr <= in_addr;
                res_idx  <= lk.hit_idx;
                res_act  <= act_now;
            end else if (state_r == ST_ISSUE) begin
                res_vld  <= 1'b1;
                res_hit  <= 1'b1;
                res_type <= q_type_r;
                res_addr <= q_addr_r;
                res_idx  <= q_idx_r;
                res_act  <= act_now;
            end
        end
    end
endmodule // ccr_resolver

//--- bench/ccr_checker.sv
// Port-level checks for the coherence collision resolver.
// Bound onto ccr_resolver from the testbench top file.
`timescale 1ns/1ps
module ccr_checker
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rstn,
    // Bookkeeping
    input wire logic               alloc_vld,
    input wire logic [ENTRY_W-1:0] alloc_idx,
    input wire txn_t               alloc_type,
    input wire logic               fin_vld,
    // Incoming and result
    input wire logic               in_vld,
    input wire logic               in_rdy,
    input wire txn_t               in_type,
    input wire logic [ADDR_W-1:0]  in_addr,
    input wire logic               res_vld,
    input wire logic               res_hit,
    input wire txn_t               res_type,
    input wire logic [ADDR_W-1:0]  res_addr,
    input wire logic [ENTRY_W-1:0] res_idx,
    input wire act_t               res_act
);
    txn_t otype_r [N_ENTRY];
    txn_t ot;

    // Outstanding type per entry, to know which table applies
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < N_ENTRY; k++)
                otype_r[k] <= TT_NONCOH;
        end else if (alloc_vld) begin
            otype_r[alloc_idx] <= alloc_type;
        end
    end
    assign ot = otype_r[res_idx];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_take;
        in_vld && in_rdy;
    endsequence
    sequence s_fin_wait;
        fin_vld && !in_rdy;
    endsequence
    sequence s_hit;
        res_vld && res_hit;
    endsequence

    AST_NONCOH_MISS: assert property (res_vld && res_type == TT_NONCOH |-> !res_hit)
        else $error("non-coherent request reported a collision");
    AST_TLB_FWD: assert property (res_vld && res_type inside {TT_TLBIE, TT_TLBSYNC}
        |-> res_act.rsp == RSP_DONE && res_act.fwd_proc)
        else $error("tlb request not forwarded with done");
    AST_ECHO: assert property (s_take |=> !res_vld ||
        (res_type == $past(in_type) && res_addr == $past(in_addr)))
        else $error("result does not carry the taken request");
    AST_REFUSE: assert property (s_take ##1 !res_vld |-> !in_rdy)
        else $error("deferred request not refusing new ones");
    AST_DEFER_ANSWER: assert property (s_fin_wait |-> ##2 res_vld)
        else $error("deferred request not answered after final response");
    AST_HOME_ERR: assert property (s_hit ##0 (ot inside {TT_READ_HOME, TT_IREAD_HOME})
        ##0 (res_type inside {TT_READ_HOME, TT_IREAD_HOME, TT_READ_TO_OWN_HOME,
        TT_DKILL_HOME, TT_CASTOUT, TT_IKILL_HOME, TT_FLUSH, TT_IO_READ_HOME})
        |-> res_act.rsp == RSP_ERROR)
        else $error("home read collision not answered with error");
    AST_NOT_OWNER: assert property (s_hit ##0 ot == TT_READ_HOME ##0 (res_type inside
        {TT_READ_OWNER, TT_READ_TO_OWN_OWNER, TT_IO_READ_OWNER})
        |-> res_act.rsp == RSP_NOT_OWNER)
        else $error("owner request not answered with not-owner");
    AST_OWNER_RETRY: assert property (s_hit ##0 (ot inside {TT_READ_OWNER,
        TT_READ_TO_OWN_OWNER}) ##0 (res_type inside {TT_READ_HOME, TT_IREAD_HOME,
        TT_READ_TO_OWN_HOME, TT_DKILL_HOME, TT_FLUSH, TT_IO_READ_HOME})
        |-> res_act.rsp == RSP_RETRY)
        else $error("home request under owner read not retried");
    AST_OWNER_ERR: assert property (s_hit ##0 (ot inside {TT_READ_OWNER,
        TT_READ_TO_OWN_OWNER}) ##0 (res_type inside {TT_READ_OWNER,
        TT_READ_TO_OWN_OWNER, TT_DKILL_SHARER, TT_IO_READ_OWNER})
        |-> res_act.rsp == RSP_ERROR)
        else $error("owner request under owner read not errored");
    AST_IKILL_SHR: assert property (s_hit ##0 res_type == TT_IKILL_SHARER |-> res_act.rsp ==
        ((ot inside {TT_READ_OWNER, TT_READ_TO_OWN_OWNER}) ? RSP_ERROR : RSP_DONE))
        else $error("sharer kill answered wrongly");
endmodule // ccr_checker

//--- bench/remote_pe_model.sv
// Remote processing element issuing coherence requests.
// Assumes a request is taken at a rising edge with in_rdy high.
`timescale 1ns/1ps
module remote_pe_model
    import ccr_pkg::*;
(
    // Clock
    input  wire logic              clk_sys,
    // Request channel
    output logic                   in_vld,
    input  wire logic              in_rdy,
    output txn_t                   in_type,
    output logic [ADDR_W-1:0]      in_addr
);
    initial begin
        in_vld = 1'b0;
        in_type = TT_NONCOH;
        in_addr = 32'h0;
    end

    // Holds the request until taken; released lines show inverted values
    task automatic send(input txn_t t, input logic [ADDR_W-1:0] a, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        #2;
        in_vld = 1'b1;
        in_type = t;
        in_addr = a;
        @(negedge clk_sys);
        while (!in_rdy)
            @(negedge clk_sys);
        @(posedge clk_sys);
        #2;
        in_vld = 1'b0;
        in_type = txn_t'(~t);
        in_addr = ~a;
    endtask
endmodule // remote_pe_model

//--- bench/ccr_resolver_test.sv
// Self-checking testbench for the coherence collision resolver.
// Drives the local bookkeeping side; remote requests come from the model.
`timescale 1ns/1ps
module ccr_resolver_test;
    import ccr_pkg::*;
    logic               clk_sys;
    logic               rstn;
    logic               alloc_vld;
    logic [ENTRY_W-1:0] alloc_idx;
    txn_t               alloc_type;
    logic [ADDR_W-1:0]  alloc_addr;
    logic               free_vld;
    logic [ENTRY_W-1:0] free_idx;
    logic [N_ENTRY-1:0] busy;
    logic               fin_vld;
    logic [ENTRY_W-1:0] fin_idx;
    logic               fin_retry;
    logic               in_vld;
    logic               in_rdy;
    txn_t               in_type;
    logic [ADDR_W-1:0]  in_addr;
    logic               res_vld;
    logic               res_hit;
    txn_t               res_type;
    logic [ADDR_W-1:0]  res_addr;
    logic [ENTRY_W-1:0] res_idx;
    act_t               res_act;
    int                 num_errors;
    int                 check_count;
    int                 seed;

    ccr_resolver i_ccr_resolver (.clk_sys(clk_sys), .rstn(rstn), .alloc_vld(alloc_vld),
        .alloc_idx(alloc_idx), .alloc_type(alloc_type), .alloc_addr(alloc_addr),
        .free_vld(free_vld), .free_idx(free_idx), .busy(busy), .fin_vld(fin_vld),
        .fin_idx(fin_idx), .fin_retry(fin_retry), .in_vld(in_vld), .in_rdy(in_rdy),
        .in_type(in_type), .in_addr(in_addr), .res_vld(res_vld), .res_hit(res_hit),
        .res_type(res_type), .res_addr(res_addr), .res_idx(res_idx), .res_act(res_act));
    remote_pe_model i_remote_pe_model (.clk_sys(clk_sys), .in_vld(in_vld), .in_rdy(in_rdy),
        .in_type(in_type), .in_addr(in_addr));

    always #10 clk_sys = ~clk_sys;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_bit(input logic g, input logic x);
        check_count++;
        if (g !== x) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic chk_rsp(input rsp_t g, input int x);
        check_count++;
        if (g !== rsp_t'(x[2:0])) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x[2:0]);
        end
    endtask

    // One local pulse: k = {final, free, alloc}
    task automatic step(input logic [2:0] k, input int e, input int v, input logic [31:0] a);
        @(posedge clk_sys);
        #2;
        {fin_vld, free_vld, alloc_vld} = k;
        {fin_idx, free_idx, alloc_idx} = {3{e[1:0]}};
        alloc_type = txn_t'(v[3:0]);
        fin_retry = v[0];
        alloc_addr = a;
        @(posedge clk_sys);
        #2;
        {fin_vld, free_vld, alloc_vld} = 3'h0;
    endtask

    function automatic bit defers(int o, int i);
        return (o == 0 && i == 6) || (o == 3 && i inside {2, 4, 6, 12, 14});
    endfunction

    // Expected response code; -1 where no code is fixed
    function automatic int exp_rsp(int o, int i, int r);
        if (i == 8 || i == 9 || i == 11)
            return (o == 2 || o == 4) && i == 11 ? 3 : 1;
        if (o == 2 || o == 4)
            return i inside {0, 1, 3, 5, 12, 13} ? 2 : i == 10 ? -1 : i == 7 ? 1 : 3;
        if (i inside {0, 1, 3, 5, 7, 10, 13} || (i == 12 && o < 3))
            return 3;
        if (o == 1 || (o == 0 && i == 6))
            return 1;
        if (o == 0)
            return 4;
        if (i == 2 || i == 4)
            return r ? 3 : 5;
        return (i == 6) ? (r ? 1 : 3) : (r ? 3 : 1);
    endfunction

    task automatic run_case(input int o, input int i, input int r, input bit miss);
        int          e;
        int          x;
        logic [31:0] a;
        logic [31:0] b;
        e = $urandom % 4;
        a = $urandom;
        b = miss ? a ^ 32'h0000_0fe0 : (($urandom % 2) ? a : a ^ 32'hff00_0000);
        step(3'b001, e, o, a);
        chk_bit(busy[e], 1'b1);
        i_remote_pe_model.send(txn_t'(i[3:0]), b, $urandom % 3);
        if (defers(o, i) && !miss) begin
            @(negedge clk_sys);
            chk_bit(in_rdy, 1'b0);
            step(3'b100, e, r, a);
        end
        @(negedge clk_sys);
        for (int n = 0; n < 8 && !res_vld; n++)
            @(negedge clk_sys);
        chk_bit(res_vld, 1'b1);
        x = exp_rsp(o, i, r);
        if (miss || i == 15) begin
            chk_bit(res_hit, 1'b0);
        end else begin
            if (x > 1 && x < 5)
                chk_bit(res_hit, 1'b1);
            if (x >= 0)
                chk_rsp(res_act.rsp, x);
            if (o == 0 && i == 6)
                chk_bit(res_act.cancel_out, r[0]);
            if (i == 8 || i == 9)
                chk_bit(res_act.fwd_proc, 1'b1);
            if ((o == 2 || o == 4) && i == 10)
                chk_bit(res_act.kill_sharers, 1'b1);
            if ((o == 2 || o == 4) && i == 7)
                chk_bit(res_act.dir_update, 1'b1);
            chk_bit(res_idx == e[1:0], 1'b1);
            if (x == 5)
                chk_bit(res_act.data_only && res_act.with_data, 1'b1);
            if (o == 3 && (i == 12 || i == 14) && r == 0)
                chk_bit(res_act.with_data, 1'b1);
        end
        step(3'b010, e, 0, a);
    endtask

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        {alloc_vld, free_vld, fin_vld, fin_retry} = 4'h0;
        {alloc_idx, free_idx, fin_idx} = 6'h00;
        alloc_type = TT_NONCOH;
        alloc_addr = 32'h0;
        num_errors = 0;
        check_count = 0;
        seed = $urandom(32'he90519a8);
        repeat (8) @(posedge clk_sys);
        #2;
        rstn = 1'b1;
        for (int o = 0; o < 5; o++)
            for (int i = 0; i < 16; i++)
                for (int r = 0; r <= int'(defers(o, i)); r++)
                    run_case(o, i, r, 1'b0);
        $display("test collision table done");
        for (int k = 0; k < 10; k++)
            run_case($urandom % 5, $urandom % 15, 0, 1'b1);
        $display("test address miss done");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule // ccr_resolver_test

bind ccr_resolver ccr_checker i_ccr_checker (.clk_sys(clk_sys), .rstn(rstn),
    .alloc_vld(alloc_vld), .alloc_idx(alloc_idx), .alloc_type(alloc_type), .fin_vld(fin_vld),
    .in_vld(in_vld), .in_rdy(in_rdy), .in_type(in_type), .in_addr(in_addr),
    .res_vld(res_vld), .res_hit(res_hit), .res_type(res_type), .res_addr(res_addr),
    .res_idx(res_idx), .res_act(res_act));
